//--- core/hgc_map.svh
// Offsets, field positions and reset values of the guest CSR bank.
// Summary of operation
// - Pending register is read-only; bit i shows guest external interrupt i pending.
// - Enable register is read/write; bit i enables guest external interrupt i.
// - Only enable bits N:1 are writable; bit 0 and bits above N read zero.
// - Line count may be zero and never exceeds 31 on a 32-bit base.
// - Enable bits pick which pending lines raise the HS-level guest interrupt.
// - VS-level external interrupt uses the selected pending bit, ignoring enables.
// - Environment configuration is 64-bit read/write; fields other than double-trap enable act only under virtualization.
// - With I/O-fence-implies-memory set, I/O fence bits also order memory.
// - Acquire/release atomics to I/O regions are then ordered as I/O and memory.
// - Page memory type enable gates VS-stage memory types; reads zero without support.
// - Access/dirty update enable selects hardware update or fault; zero without support.
// - Landing pad disabled in VS-mode: expected state stays not-expected and pad is a no-op.
// - Shadow stack disabled under virtualization: fallbacks, reserved pattern, swap traps.
// - Double-trap enable clear forces the VS-level double-trap flag to read zero.
// - On a 32-bit base an upper alias reaches configuration bits 63:32.
// - Counter access register is 32-bit: cycle, time, retired, then performance counters.
// - Virtualized read with guest bit clear and machine bit set raises virtual-instruction.
// - Guest bit set permits the read; VU-mode also needs the supervisor bit.
// - Counter access register always exists; unimplemented bits are hardwired to zero.
// - Summary pending is set exactly when pending AND enable is nonzero.
// - VS external pending ORs the selector-chosen pending bit with its other sources.
`ifndef HGC_MAP_SVH
`define HGC_MAP_SVH
`define HGC_OFS_PEND 12'h000
`define HGC_OFS_ENAB 12'h004
`define HGC_OFS_CFG_LO 12'h008
`define HGC_OFS_CFG_HI 12'h00C
`define HGC_OFS_CTR 12'h010
`define HGC_OFS_CTRL 12'h014
`define HGC_OFS_STAT 12'h018
`define HGC_LINES 8
`define HGC_MAX_LINES 31
`define HGC_IO_FENCE_IMPLIES_MEM_BIT 0
`define HGC_LPE_BIT 2
`define HGC_SSE_BIT 3
`define HGC_DTE_BIT 59
`define HGC_HW_ACCESS_DIRTY_UPDATE_ENABLE_BIT 61
`define HGC_PAGE_MEM_TYPE_ENABLE_BIT 62
`define HGC_HAS_PBMT 1'b1
`define HGC_HAS_ADU 1'b1
`define HGC_CTR_MASK 32'h0000_0FFF
`define HGC_CFG_RST 64'h0000_0000_0000_0000
`define HGC_ENAB_RST 32'h0000_0000
`define HGC_CTR_RST 32'h0000_0000
`define HGC_SEL_W 6
`define HGC_STAT_SUMMARY 0
`define HGC_STAT_VS_EXTERNAL_IRQ_PENDING 1
`define HGC_STAT_ELP 2
`define HGC_LP_NOT_EXPECTED 1'b0
`define HGC_LP_EXPECTED 1'b1
`endif

//--- core/hgc_pkg.sv
// Types shared by the guest CSR bank.
package hgc_pkg;
   typedef enum logic [2:0] {
      HGC_R_NONE = 3'b000,
      HGC_R_PEND = 3'b001,
      HGC_R_ENAB = 3'b010,
      HGC_R_CFGL = 3'b011,
      HGC_R_CFGH = 3'b100,
      HGC_R_CTR = 3'b101,
      HGC_R_CTRL = 3'b110,
      HGC_R_STAT = 3'b111
   } hgc_reg_t;
endpackage : hgc_pkg

//--- core/hgc_guest_csr_bank.sv
// Hypervisor guest CSR bank with an APB register port and hart-side outputs.
//
// Our own choices: the APB interface to the registers and the placing of the registers.
`timescale 1ns/100ps
`include "hgc_map.svh"

module hgc_guest_csr_bank (
   input wire logic ref_clk,
   input wire logic rst,
   // APB slave.
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // Interrupt controller and other interrupt sources.
   input wire logic [31:0] guest_irq_in,
   input wire logic hvip_vs_ext_irq,
   input wire logic plat_vs_ext_irq,
   output logic hs_guest_irq_summary,
   output logic vs_external_irq_pending,
   // Hart context.
   input wire logic virt_mode,
   input wire logic vu_mode,
   // Fence and atomic ordering.
   input wire logic [3:0] fence_io_bits,
   input wire logic amo_io_region,
   input wire logic amo_aq_rl,
   output logic [3:0] fence_mem_bits,
   output logic amo_order_both,
   // Translation controls.
   output logic vs_page_mem_type_active,
   output logic vs_hw_ad_update,
   output logic vs_ad_fault,
   // Landing pads.
   input wire logic elp_set,
   input wire logic landing_pad_instruction,
   output logic expected_landing_pad_state,
   output logic landing_pad_is_nop,
   // Shadow stacks and double trap.
   input wire logic machine_shadow_stack_enable,
   input wire logic shadow_stack_swap,
   output logic shadow_stack_fallback,
   output logic shadow_stack_swap_trap,
   output logic vs_double_trap_flag_ro_zero,
   // Counter reads.
   input wire logic ctr_read,
   input wire logic [4:0] ctr_index,
   input wire logic [31:0] machine_ctr_enable,
   input wire logic [31:0] super_ctr_enable,
   output logic ctr_read_ok,
   output logic ctr_virt_instr_trap
);

   // --------------------------------------------------------------------
   // Constants and decoding helpers
   // --------------------------------------------------------------------

   // Configuration bits that software can change; all others stay zero.
   localparam logic [63:0] CFG_ONE = 64'h0000_0000_0000_0001;
   localparam logic [63:0] CFG_WMASK =
      (CFG_ONE << `HGC_IO_FENCE_IMPLIES_MEM_BIT) |
      (CFG_ONE << `HGC_LPE_BIT) |
      (CFG_ONE << `HGC_SSE_BIT) |
      (CFG_ONE << `HGC_DTE_BIT) |
      ({63'h0, `HGC_HAS_ADU} << `HGC_HW_ACCESS_DIRTY_UPDATE_ENABLE_BIT) |
      ({63'h0, `HGC_HAS_PBMT} << `HGC_PAGE_MEM_TYPE_ENABLE_BIT);

   // Address decode, shared by the read mux and the write logic.
   function automatic hgc_pkg::hgc_reg_t hgc_decode(
      input logic [11:0] a
   );
      case (a)
         `HGC_OFS_PEND: hgc_decode = hgc_pkg::HGC_R_PEND;
         `HGC_OFS_ENAB: hgc_decode = hgc_pkg::HGC_R_ENAB;
         `HGC_OFS_CFG_LO: hgc_decode = hgc_pkg::HGC_R_CFGL;
         `HGC_OFS_CFG_HI: hgc_decode = hgc_pkg::HGC_R_CFGH;
         `HGC_OFS_CTR: hgc_decode = hgc_pkg::HGC_R_CTR;
         `HGC_OFS_CTRL: hgc_decode = hgc_pkg::HGC_R_CTRL;
         `HGC_OFS_STAT: hgc_decode = hgc_pkg::HGC_R_STAT;
         default: hgc_decode = hgc_pkg::HGC_R_NONE;
      endcase
   endfunction : hgc_decode

   // Byte-lane merge of a write into an existing word.
   function automatic logic [31:0] hgc_merge(
      input logic [31:0] old,
      input logic [31:0] wd,
      input logic [3:0] be
   );
      logic [31:0] r;
      r = old;
      for (int k = 0; k < 4; k++) begin
         if (be[k]) begin
            r[8*k +: 8] = wd[8*k +: 8];
         end
      end
      return r;
   endfunction : hgc_merge

   // --------------------------------------------------------------------
   // Declarations
   // --------------------------------------------------------------------

   logic [31:0] line_mask;
   logic [31:0] pend_q;
   logic [31:0] enab_q;
   logic [63:0] cfg_q;
   logic [31:0] ctr_q;
   logic [`HGC_SEL_W-1:0] sel_q;
   logic summary_q;
   logic vs_external_irq_pending_q;
   logic elp_q;
   logic [31:0] prdata_q;
   logic [31:0] rdata_d;
   logic pready_q;
   logic pslverr_q;
   logic [3:0] fence_mem_q;
   logic amo_both_q;
   logic pbmt_q;
   logic ad_upd_q;
   logic ad_fault_q;
   logic lp_nop_q;
   logic ss_fb_q;
   logic ss_trap_q;
   logic dt_zero_q;
   logic ctr_ok_q;
   logic ctr_trap_q;
   logic wr_commit;
   logic setup;
   logic vs_mode;
   logic sel_bit;
   logic hc_bit;
   hgc_pkg::hgc_reg_t wr_reg;
   hgc_pkg::hgc_reg_t rd_reg;

   // --------------------------------------------------------------------
   // Implemented guest lines
   // --------------------------------------------------------------------

   // Lines fill from bit 1 upward; bit 0 never exists.  A count of zero
   // leaves both registers all zero.
   for (genvar i = 0; i < 32; i++) begin : g_line
      assign line_mask[i] = (i >= 1) && (i <= `HGC_LINES) &&
                            (i <= `HGC_MAX_LINES);
   end

   // --------------------------------------------------------------------
   // APB slave
   // --------------------------------------------------------------------

   // Zero wait states: the answer is prepared at the setup edge, so the
   // read data are a snapshot of that edge, not of the access edge.
   assign setup = psel & ~penable;
   assign wr_commit = psel & penable & pready_q & pwrite & ~pslverr_q;
   assign wr_reg = hgc_decode(paddr);
   assign rd_reg = hgc_decode(paddr);

   // Read mux; reserved and unimplemented bits read as zero.
   always_comb begin
      case (rd_reg)
         hgc_pkg::HGC_R_PEND: rdata_d = pend_q;
         hgc_pkg::HGC_R_ENAB: rdata_d = enab_q;
         hgc_pkg::HGC_R_CFGL: rdata_d = cfg_q[31:0];
         hgc_pkg::HGC_R_CFGH: rdata_d = cfg_q[63:32];
         hgc_pkg::HGC_R_CTR: rdata_d = ctr_q;
         hgc_pkg::HGC_R_CTRL: rdata_d = {26'h0, sel_q};
         hgc_pkg::HGC_R_STAT: rdata_d = {29'h0, elp_q, vs_external_irq_pending_q, summary_q};
         default: rdata_d = 32'h0000_0000;
      endcase
   end

   // Handshake: pready rises in the first access cycle and falls after it.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= 32'h0000_0000;
      end else if (setup) begin
         pready_q <= 1'b1;
         pslverr_q <= (rd_reg == hgc_pkg::HGC_R_NONE);
         prdata_q <= pwrite ? 32'h0000_0000 : rdata_d;
      end else begin
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
      end
   end

   // --------------------------------------------------------------------
   // Software-visible registers
   // --------------------------------------------------------------------

   // Pending bits follow the controller every cycle; a write to this
   // offset completes normally but stores nothing.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pend_q <= 32'h0000_0000;
      end else begin
         pend_q <= guest_irq_in & line_mask;
      end
   end

   // Enable register, masked to the implemented lines.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         enab_q <= `HGC_ENAB_RST;
      end else if (wr_commit && wr_reg == hgc_pkg::HGC_R_ENAB) begin
         enab_q <= hgc_merge(enab_q, pwdata, pstrb) & line_mask;
      end
   end

   // 64-bit environment configuration, low half and upper alias.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         cfg_q <= `HGC_CFG_RST;
      end else if (wr_commit && wr_reg == hgc_pkg::HGC_R_CFGL) begin
         cfg_q[31:0] <= hgc_merge(cfg_q[31:0], pwdata, pstrb) &
                        CFG_WMASK[31:0];
      end else if (wr_commit && wr_reg == hgc_pkg::HGC_R_CFGH) begin
         cfg_q[63:32] <= hgc_merge(cfg_q[63:32], pwdata, pstrb) &
                         CFG_WMASK[63:32];
      end
   end

   // Counter access enables; unimplemented counters are hardwired zero,
   // so any value may be written and only legal ones are kept.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctr_q <= `HGC_CTR_RST;
      end else if (wr_commit && wr_reg == hgc_pkg::HGC_R_CTR) begin
         ctr_q <= hgc_merge(ctr_q, pwdata, pstrb) & `HGC_CTR_MASK;
      end
   end

   // Guest-line selector, normally a field of the hypervisor status.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         sel_q <= 6'h00;
      end else if (wr_commit && wr_reg == hgc_pkg::HGC_R_CTRL &&
                   pstrb[0]) begin
         sel_q <= pwdata[`HGC_SEL_W-1:0];
      end
   end

   // --------------------------------------------------------------------
   // Interrupt outputs
   // --------------------------------------------------------------------

   // Selector values above 31 pick nothing rather than aliasing a line.
   assign sel_bit = (sel_q[5] == 1'b0) ? pend_q[sel_q[4:0]] : 1'b0;

   // Summary uses the enables; the VS-level path deliberately does not.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         summary_q <= 1'b0;
         vs_external_irq_pending_q <= 1'b0;
      end else begin
         summary_q <= |(pend_q & enab_q);
         vs_external_irq_pending_q <= sel_bit | hvip_vs_ext_irq | plat_vs_ext_irq;
      end
   end

   // --------------------------------------------------------------------
   // Environment controls toward the hart
   // --------------------------------------------------------------------

   assign vs_mode = virt_mode & ~vu_mode;

   // Both fence and atomic controls are qualified by virtualization mode.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         fence_mem_q <= 4'h0;
         amo_both_q <= 1'b0;
      end else begin
         fence_mem_q <= fence_io_bits &
                        {4{virt_mode & cfg_q[`HGC_IO_FENCE_IMPLIES_MEM_BIT]}};
         amo_both_q <= virt_mode & cfg_q[`HGC_IO_FENCE_IMPLIES_MEM_BIT] &
                       amo_io_region & amo_aq_rl;
      end
   end

   // Translation controls; without support the bits never set.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         pbmt_q <= 1'b0;
         ad_upd_q <= 1'b0;
         ad_fault_q <= 1'b0;
      end else begin
         pbmt_q <= virt_mode & cfg_q[`HGC_PAGE_MEM_TYPE_ENABLE_BIT];
         ad_upd_q <= virt_mode & cfg_q[`HGC_HW_ACCESS_DIRTY_UPDATE_ENABLE_BIT];
         ad_fault_q <= virt_mode & ~cfg_q[`HGC_HW_ACCESS_DIRTY_UPDATE_ENABLE_BIT];
      end
   end

   // Expected-landing-pad state; a disabled VS-mode pins it, which also
   // wins over a set request arriving in the same cycle.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         elp_q <= `HGC_LP_NOT_EXPECTED;
      end else if (vs_mode && !cfg_q[`HGC_LPE_BIT]) begin
         elp_q <= `HGC_LP_NOT_EXPECTED;
      end else if (elp_set) begin
         elp_q <= `HGC_LP_EXPECTED;
      end else if (landing_pad_instruction) begin
         elp_q <= `HGC_LP_NOT_EXPECTED;
      end
   end

   // Landing pad, shadow stack and double-trap qualifiers.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         lp_nop_q <= 1'b0;
         ss_fb_q <= 1'b0;
         ss_trap_q <= 1'b0;
         dt_zero_q <= 1'b1;
      end else begin
         lp_nop_q <= vs_mode & ~cfg_q[`HGC_LPE_BIT];
         ss_fb_q <= virt_mode & ~cfg_q[`HGC_SSE_BIT];
         ss_trap_q <= virt_mode & ~cfg_q[`HGC_SSE_BIT] &
                      machine_shadow_stack_enable & shadow_stack_swap;
         dt_zero_q <= ~cfg_q[`HGC_DTE_BIT];
      end
   end

   // --------------------------------------------------------------------
   // Counter access check
   // --------------------------------------------------------------------

   assign hc_bit = ctr_q[ctr_index];

   // Outside virtualization this bank never blocks a read; a machine
   // enable of zero is another block's illegal-instruction case.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         ctr_ok_q <= 1'b0;
         ctr_trap_q <= 1'b0;
      end else begin
         ctr_ok_q <= ctr_read & (~virt_mode |
                     (hc_bit & machine_ctr_enable[ctr_index] &
                      (~vu_mode | super_ctr_enable[ctr_index])));
         ctr_trap_q <= ctr_read & virt_mode & ~hc_bit &
                       machine_ctr_enable[ctr_index];
      end
   end

   // --------------------------------------------------------------------
   // Outputs
   // --------------------------------------------------------------------

   assign prdata = prdata_q;
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign hs_guest_irq_summary = summary_q;
   assign vs_external_irq_pending = vs_external_irq_pending_q;
   assign fence_mem_bits = fence_mem_q;
   assign amo_order_both = amo_both_q;
   assign vs_page_mem_type_active = pbmt_q;
   assign vs_hw_ad_update = ad_upd_q;
   assign vs_ad_fault = ad_fault_q;
   assign expected_landing_pad_state = elp_q;
   assign landing_pad_is_nop = lp_nop_q;
   assign shadow_stack_fallback = ss_fb_q;
   assign shadow_stack_swap_trap = ss_trap_q;
   assign vs_double_trap_flag_ro_zero = dt_zero_q;
   assign ctr_read_ok = ctr_ok_q;
   assign ctr_virt_instr_trap = ctr_trap_q;

endmodule : hgc_guest_csr_bank

//--- testbench/hgc_guest_csr_bank_props.sv
// Concurrent checks on the ports of the guest CSR bank.
`timescale 1ns/100ps

module hgc_guest_csr_bank_props (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic psel,
   input wire logic penable,
   input wire logic [31:0] prdata,
   input wire logic pready,
   input wire logic pslverr,
   input wire logic [31:0] guest_irq_in,
   input wire logic hvip_vs_ext_irq,
   input wire logic hs_guest_irq_summary,
   input wire logic vs_external_irq_pending,
   input wire logic virt_mode,
   input wire logic [3:0] fence_io_bits,
   input wire logic [3:0] fence_mem_bits,
   input wire logic vs_hw_ad_update,
   input wire logic vs_ad_fault,
   input wire logic elp_set,
   input wire logic expected_landing_pad_state,
   input wire logic landing_pad_is_nop,
   input wire logic ctr_read,
   input wire logic ctr_read_ok,
   input wire logic ctr_virt_instr_trap
);
   // ----------
   // Checks
   // ----------
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);

   // A transfer is a setup cycle followed by a one-cycle answer.
   sequence setup_s;
      psel && !penable;
   endsequence
   sequence answer_s;
      pready ##1 !pready;
   endsequence

   AST_READY_NEXT: assert property (setup_s |=> answer_s)
      else $error("pready did not pulse once after setup");
   AST_ERR_READY: assert property (pslverr |-> pready && prdata == '0)
      else $error("error response without ready or with data");
   // Memory order bits may only echo I/O bits, and only in virtual mode.
   AST_FENCE_SUBSET: assert property (!$past(rst) |->
      fence_mem_bits == (fence_mem_bits & $past(fence_io_bits)
      & {4{$past(virt_mode)}}))
      else $error("fence memory bits without cause");
   AST_AD_ONE_HOT: assert property (!$past(rst) |->
      !(vs_hw_ad_update && vs_ad_fault)
      && ((vs_hw_ad_update || vs_ad_fault) == $past(virt_mode)))
      else $error("access dirty controls inconsistent");
   // Summary needs an implemented line two cycles earlier.
   AST_SUMMARY_CAUSE: assert property (hs_guest_irq_summary |->
      |($past(guest_irq_in, 2) & 32'h0000_01FE))
      else $error("summary set without implemented pending line");
   AST_VS_EXTERNAL_IRQ_PENDING_OTHER: assert property (
      !$past(rst) && $past(hvip_vs_ext_irq) |-> vs_external_irq_pending)
      else $error("vs external pending missed other source");
   AST_ELP_CAUSE: assert property (
      $rose(expected_landing_pad_state) |-> $past(elp_set))
      else $error("expected landing pad rose without request");
   AST_NOP_NO_ELP: assert property (
      landing_pad_is_nop |-> !expected_landing_pad_state)
      else $error("landing pad state updated while disabled");
   AST_CTR_TRAP: assert property (ctr_virt_instr_trap |->
      !ctr_read_ok && $past(ctr_read && virt_mode))
      else $error("counter trap without virtual read");
   AST_CTR_PLAIN: assert property (
      !$past(rst) && $past(ctr_read && !virt_mode) |-> ctr_read_ok)
      else $error("plain counter read refused");
   AST_CTR_IDLE: assert property (!$past(ctr_read) |->
      !ctr_read_ok ##0 !ctr_virt_instr_trap)
      else $error("counter result without read");
endmodule : hgc_guest_csr_bank_props

bind hgc_guest_csr_bank hgc_guest_csr_bank_props
   hgc_guest_csr_bank_props_inst (.ref_clk, .rst, .psel, .penable, .prdata,
   .pready, .pslverr, .guest_irq_in, .hvip_vs_ext_irq, .hs_guest_irq_summary,
   .vs_external_irq_pending, .virt_mode, .fence_io_bits, .fence_mem_bits,
   .vs_hw_ad_update, .vs_ad_fault, .elp_set, .expected_landing_pad_state,
   .landing_pad_is_nop, .ctr_read, .ctr_read_ok, .ctr_virt_instr_trap);

//--- testbench/hgc_irq_ctrl_model.sv
// Interrupt controller model driving per-virtual-hart pending levels.
`timescale 1ns/100ps

module hgc_irq_ctrl_model (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic slow,
   input wire logic [31:0] req_lines,
   output logic [31:0] guest_irq_in
);
   logic [31:0] stage_q;

   // Levels follow requests one cycle later, or two when slow, as a
   // controller with a collection stage would report them.
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         stage_q <= '0;
         guest_irq_in <= '0;
      end else begin
         stage_q <= req_lines;
         guest_irq_in <= slow ? stage_q : req_lines;
      end
   end
endmodule : hgc_irq_ctrl_model

//--- testbench/hgc_guest_csr_bank_bench.sv
// Self-checking bench for the guest CSR bank.
`timescale 1ns/100ps

module hgc_guest_csr_bank_bench;
   // ----------
   // Signals
   // ----------
   logic ref_clk = '0, rst = '1, psel = '0, penable = '0, pwrite = '0;
   logic hvip_vs_ext_irq = '0, plat_vs_ext_irq = '0, virt_mode = '0;
   logic vu_mode = '0, amo_io_region = '0, amo_aq_rl = '0, elp_set = '0;
   logic landing_pad_instruction = '0, machine_shadow_stack_enable = '0;
   logic shadow_stack_swap = '0, ctr_read = '0, slow = '0;
   logic [11:0] paddr = '0;
   logic [31:0] pwdata = '0, req_lines = '0, r;
   logic [31:0] machine_ctr_enable = '0, super_ctr_enable = '0;
   logic [3:0] pstrb = '0, fence_io_bits = '0, fence_mem_bits;
   logic [4:0] ctr_index = '0;
   logic [31:0] prdata, guest_irq_in;
   logic pready, pslverr, hs_guest_irq_summary, vs_external_irq_pending;
   logic amo_order_both, vs_page_mem_type_active, vs_hw_ad_update;
   logic vs_ad_fault, expected_landing_pad_state, landing_pad_is_nop;
   logic shadow_stack_fallback, shadow_stack_swap_trap, ctr_read_ok;
   logic vs_double_trap_flag_ro_zero, ctr_virt_instr_trap;
   logic [32:0] exp_q [$];
   int n_fail = 0;
   int check_count = 0;
   // Lines are {virt, vu, index, ok, trap}; index 12 is hardwired off.
   localparam logic [8:0] CTR_TAB [7] = '{9'h102, 9'h105, 9'h10A, 9'h131,
      9'h180, 9'h18A, 9'h006};
   // Lines are {summary, vs pending, hvip, platform, request lines}.
   localparam logic [35:0] IRQ_TAB [5] = '{36'h0_0000_0201,
      36'h8_0000_0008, 36'h4_0000_0020, 36'h6_0000_0000, 36'h5_0000_0000};
   wire [12:0] hart_o = {fence_mem_bits, amo_order_both,
      vs_page_mem_type_active, vs_hw_ad_update, vs_ad_fault,
      shadow_stack_fallback, shadow_stack_swap_trap,
      vs_double_trap_flag_ro_zero, expected_landing_pad_state,
      landing_pad_is_nop};

   always #50 ref_clk = ~ref_clk;

   hgc_guest_csr_bank hgc_guest_csr_bank_inst (.ref_clk, .rst, .psel,
      .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
      .guest_irq_in, .hvip_vs_ext_irq, .plat_vs_ext_irq, .hs_guest_irq_summary,
      .vs_external_irq_pending, .virt_mode, .vu_mode, .fence_io_bits,
      .amo_io_region, .amo_aq_rl, .fence_mem_bits, .amo_order_both,
      .vs_page_mem_type_active, .vs_hw_ad_update, .vs_ad_fault, .elp_set,
      .landing_pad_instruction, .expected_landing_pad_state,
      .landing_pad_is_nop, .machine_shadow_stack_enable, .shadow_stack_swap,
      .shadow_stack_fallback, .shadow_stack_swap_trap,
      .vs_double_trap_flag_ro_zero, .ctr_read, .ctr_index,
      .machine_ctr_enable, .super_ctr_enable, .ctr_read_ok,
      .ctr_virt_instr_trap);

   hgc_irq_ctrl_model hgc_irq_ctrl_model_inst (.ref_clk, .rst, .slow,
      .req_lines, .guest_irq_in);

   // ----------
   // Tasks
   // ----------
   task automatic check(input string nm, input logic [63:0] seen,
      input logic [63:0] ex);
      check_count++;
      if (seen !== ex) begin
         n_fail++;
         $display("ERROR %s expected %h seen %h", nm, ex, seen);
      end
   endtask : check

   // One APB transfer; the expected {error, data} is noted for the monitor.
   task automatic apb(input logic [11:0] a, input logic w,
      input logic [31:0] d, input logic [3:0] s, input logic [32:0] e);
      @(posedge ref_clk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      pstrb <= s;
      exp_q.push_back(e);
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1) @(posedge ref_clk);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Hart-side outputs lag their causes by a few registered stages; the
   // caller compares the values that stood just before the last edge.
   task automatic settle;
      repeat (5) @(posedge ref_clk);
   endtask : settle

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask : print_verdict

   // The monitor takes the oldest note whenever an answer is sampled.
   always @(posedge ref_clk) begin
      if (psel && penable && pready === 1'b1) begin
         if (exp_q.size() > 0)
            check("apb", {pslverr, prdata}, exp_q.pop_front());
         else check("apb_extra", 1'b1, 1'b0);
      end
   end

   // A hang counts as a mismatch; the run is only a few hundred cycles.
   initial begin
      repeat (3000) @(posedge ref_clk);
      n_fail++;
      $display("ERROR watchdog expected done seen timeout");
      print_verdict();
   end

   // ----------
   // Scenarios
   // ----------
   initial begin
      r = $urandom(99);
      repeat (16) @(posedge ref_clk);
      rst <= 1'b0;
      settle();
      check("hart", hart_o, 13'h0004);
      for (int i = 1; i < 6; i++) apb(12'(4 * i), 0, 0, 0, 0);
      r = $urandom();
      apb(12'h004, 1, r, 4'hF, 0);
      apb(12'h004, 0, 0, 0, {1'b0, r & 32'h0000_01FE});
      apb(12'h008, 1, 32'hFFFF_FFFF, 4'hF, 0);
      apb(12'h008, 0, 0, 0, 33'h0_0000_000D);
      apb(12'h00C, 1, 32'hFFFF_FFFF, 4'hF, 0);
      apb(12'h00C, 0, 0, 0, 33'h0_6800_0000);
      apb(12'h010, 1, 32'hFFFF_FFFF, 4'hF, 0);
      apb(12'h010, 0, 0, 0, 33'h0_0000_0FFF);
      apb(12'h01C, 0, 0, 0, 33'h1_0000_0000);
      @(posedge ref_clk);
      virt_mode <= 1'b1;
      fence_io_bits <= 4'b1010;
      amo_io_region <= 1'b1;
      amo_aq_rl <= 1'b1;
      machine_shadow_stack_enable <= 1'b1;
      shadow_stack_swap <= 1'b1;
      elp_set <= 1'b1;
      settle();
      check("hart", hart_o, 13'h15C2);
      elp_set <= 1'b0;
      landing_pad_instruction <= 1'b1;
      settle();
      check("hart", hart_o, 13'h15C0);
      apb(12'h008, 1, 0, 4'h1, 0);
      @(posedge ref_clk);
      elp_set <= 1'b1;
      landing_pad_instruction <= 1'b0;
      settle();
      check("hart", hart_o, 13'h00D9);
      elp_set <= 1'b0;
      virt_mode <= 1'b0;
      settle();
      check("hart", hart_o, 13'h0000);
      apb(12'h010, 1, 32'h0000_0005, 4'hF, 0);
      @(posedge ref_clk);
      machine_ctr_enable <= $urandom() | 32'h0000_1007;
      super_ctr_enable <= 32'h0000_0004;
      ctr_read <= 1'b1;
      for (int i = 0; i < 7; i++) begin
         {virt_mode, vu_mode, ctr_index} <= CTR_TAB[i][8:2];
         settle();
         check("ctr", {ctr_read_ok, ctr_virt_instr_trap},
            CTR_TAB[i][1:0]);
      end
      ctr_read <= 1'b0;
      slow <= 1'b1;
      apb(12'h004, 1, 32'h0000_0008, 4'hF, 0);
      apb(12'h014, 1, 32'h0000_0005, 4'hF, 0);
      for (int i = 0; i < 5; i++) begin
         @(posedge ref_clk);
         {hvip_vs_ext_irq, plat_vs_ext_irq, req_lines} <= IRQ_TAB[i][33:0];
         settle();
         check("irq", {hs_guest_irq_summary, vs_external_irq_pending},
            IRQ_TAB[i][35:34]);
         apb(12'h000, 0, 0, 0,
            {1'b0, IRQ_TAB[i][31:0] & 32'h0000_01FE});
      end
      apb(12'h014, 0, 0, 0, 33'h0_0000_0005);
      apb(12'h018, 0, 0, 0, 33'h0_0000_0002);
      r = $urandom();
      req_lines <= r;
      settle();
      apb(12'h000, 1, 32'hFFFF_FFFF, 4'hF, 0);
      apb(12'h000, 0, 0, 0, {1'b0, r & 32'h0000_01FE});
      @(posedge ref_clk);
      check("apb_left", exp_q.size(), 0);
      print_verdict();
   end
endmodule : hgc_guest_csr_bank_bench
